// >>> verilog/burst_bus_defines.vh
// Shared constants for the burst bus control block.
`ifndef BURST_BUS_DEFINES_VH
`define BURST_BUS_DEFINES_VH
`define BB_DATA_W 16
`define BB_ADDR_W 32
`define BB_FIFO_DEPTH 8
`define BB_FIFO_AW 3
`define BB_BURST_W 2
`define BB_KIND_READ 2'h0
`define BB_KIND_WRITE 2'h1
`define BB_KIND_RMW 2'h2
`define BB_KIND_IACK 2'h3
`endif

// >>> verilog/bb_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module bb_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output reg [WIDTH-1:0] out_data_o,
  output reg out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  wire load;
  wire [AW:0] fill;
  // The output register is one of the DEPTH slots, so the FIFO never holds more than DEPTH words.
  assign fill = cnt_q + {{AW{1'b0}}, out_valid_o};
  assign in_ready_o = (fill != DEPTH);
  assign push = in_valid_i && in_ready_o;
  // The output register counts as storage, so memory is refilled into it when it drains.
  assign load = (cnt_q != 0) && (!out_valid_o || out_ready_i);
  assign pop = load;
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        out_data_o <= mem_q[rd_q];
        rd_q <= rd_q + 1'b1;
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // bb_fifo
`default_nettype wire

// >>> verilog/burst_bus_control.v
// Bus state sequencer and control-signal generator for the burst bus.
`timescale 1ns/1ps
`default_nettype none
`include "burst_bus_defines.vh"
// Contract
// - Write/read indicator set in address state, held through all data states.
// - Data-window strobe asserted during data states.
// - Own drivers released before the data-window strobe asserts; the code releases them on the same edge that asserts the strobe.
// - Data-window strobe deasserts only after read data captured.
// - Data-window strobe high during reset.
// - Direction low for reads and acknowledges, high for writes and reset.
// - Direction never changes while data-window strobe asserted.
// - No ready in a data state inserts wait states until ready.
// - Bus-lock is shared open-drain active low.
// - Read-modify-write waits while another agent holds bus-lock.
// - Free lock is asserted in read address state of read-modify-write.
// - Lock released in address state of the completing write.
// - Lock also asserted during interrupt-acknowledge transactions.
// - Lock low at reset end floats all outputs until next reset.
// - Address strobe asserted in address state, deasserted in data state.
// - Burst-final low in last data state including its waits; in multi-beat bursts the code lowers it one cycle after that state begins.
module burst_bus_control (
  input wire core_clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire req_valid_i,
  output reg req_ready_o,
  input wire [1:0] req_kind_i,
  input wire [31:0] req_addr_i,
  input wire [1:0] req_beats_i,
  input wire [15:0] wr_data_i,
  input wire wr_valid_i,
  output wire wr_ready_o,
  output reg [15:0] rd_data_o,
  output reg rd_valid_o,
  input wire rd_ready_i,
  output reg busy_o,
  output reg [15:0] ad_o,
  output reg ad_oe_o,
  input wire [15:0] ad_i,
  output reg [31:16] addr_hi_o,
  output reg addr_hi_oe_o,
  output reg write_read_o,
  output reg address_strobe_n_o,
  output reg data_window_strobe_n_o,
  output reg transceiver_direction_o,
  output reg burst_final_n_o,
  output reg ctl_oe_o,
  input wire ready_n_i,
  input wire lock_n_i,
  output reg lock_n_o,
  output reg lock_oe_o,
  output reg float_all_mode_o
);
  // ****************************************
  // States
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_LOCKWAIT = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_RECOV = 3'h4;
  localparam ST_FLOAT = 3'h5;
  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [2:0] rdy_sync_q;
  reg [2:0] lock_sync_q;
  reg ready_q;
  reg lock_low_q;
  reg [15:0] ad_s1_q;
  reg [15:0] ad_s2_q;
  // Ready and lock pass three flops; a change counts only when stages two and three agree.
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdy_sync_q <= 3'h7;
      // The lock synchroniser keeps sampling in reset so its last stage holds the strap.
      lock_sync_q <= {lock_sync_q[1:0], lock_n_i};
      ready_q <= 1'b0;
      lock_low_q <= 1'b0;
      ad_s1_q <= 16'h0000;
      ad_s2_q <= 16'h0000;
    end else if (ce_i) begin
      rdy_sync_q <= {rdy_sync_q[1:0], ready_n_i};
      lock_sync_q <= {lock_sync_q[1:0], lock_n_i};
      ad_s1_q <= ad_i;
      ad_s2_q <= ad_s1_q;
      if (rdy_sync_q[1] == rdy_sync_q[2]) begin
        ready_q <= !rdy_sync_q[2];
      end
      if (lock_sync_q[1] == lock_sync_q[2]) begin
        lock_low_q <= !lock_sync_q[2];
      end
    end
  end
  // ****************************************
  // Write data FIFO
  // ****************************************
  wire [15:0] wf_data;
  wire wf_valid;
  reg wf_take;
  bb_fifo #(
    .WIDTH(`BB_DATA_W),
    .DEPTH(`BB_FIFO_DEPTH),
    .AW(`BB_FIFO_AW)
  ) u_wr_fifo (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .in_data_i(wr_data_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .out_data_o(wf_data),
    .out_valid_o(wf_valid),
    .out_ready_i(wf_take)
  );
  function is_write;
    input [1:0] kind;
    input rmw_wr;
    begin
      is_write = (kind == `BB_KIND_WRITE) || ((kind == `BB_KIND_RMW) && rmw_wr);
    end
  endfunction
  // ****************************************
  // Sequencer
  // ****************************************
  reg [2:0] st_q;
  reg [1:0] kind_q;
  reg [31:0] addr_q;
  reg [1:0] beats_q;
  reg [1:0] beat_q;
  reg rmw_wr_q;
  reg strap_seen_q;
  reg rdy_used_q;
  wire rdy_hit;
  wire cur_wr;
  wire last_beat;
  // A write beat cannot start without data, so a lagging source stalls the bus.
  wire data_ok;
  assign cur_wr = is_write(kind_q, rmw_wr_q);
  assign last_beat = (beat_q == beats_q);
  assign data_ok = !cur_wr || wf_valid;
  // The filtered ready stands at least two cycles, so each assertion completes one beat only.
  assign rdy_hit = ready_q && !rdy_used_q;
  always @* begin
    wf_take = 1'b0;
    if (st_q == ST_DATA && cur_wr && rdy_hit && wf_valid && address_strobe_n_o) begin
      wf_take = 1'b1;
    end
  end
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q <= ST_IDLE;
      kind_q <= `BB_KIND_READ;
      addr_q <= 32'h0000_0000;
      beats_q <= 2'h0;
      beat_q <= 2'h0;
      rmw_wr_q <= 1'b0;
      strap_seen_q <= 1'b0;
      rdy_used_q <= 1'b0;
      req_ready_o <= 1'b0;
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
      busy_o <= 1'b0;
      ad_o <= 16'h0000;
      ad_oe_o <= 1'b0;
      addr_hi_o <= 16'h0000;
      addr_hi_oe_o <= 1'b0;
      write_read_o <= 1'b0;
      address_strobe_n_o <= 1'b1;
      data_window_strobe_n_o <= 1'b1;
      transceiver_direction_o <= 1'b1;
      burst_final_n_o <= 1'b1;
      ctl_oe_o <= 1'b1;
      lock_n_o <= 1'b1;
      lock_oe_o <= 1'b0;
      float_all_mode_o <= 1'b0;
    end else if (ce_i) begin
      req_ready_o <= 1'b0;
      if (!ready_q) begin
        rdy_used_q <= 1'b0;
      end
      if (rd_valid_o && rd_ready_i) begin
        rd_valid_o <= 1'b0;
      end
      if (!strap_seen_q) begin
        // Strap is taken on the first clock after reset release from the last lock stage.
        strap_seen_q <= 1'b1;
        if (!lock_sync_q[2]) begin
          st_q <= ST_FLOAT;
          float_all_mode_o <= 1'b1;
          ctl_oe_o <= 1'b0;
        end
      end else begin
        case (st_q)
          ST_IDLE: begin
            busy_o <= 1'b0;
            if (req_valid_i && !req_ready_o) begin
              req_ready_o <= 1'b1;
              kind_q <= req_kind_i;
              addr_q <= req_addr_i;
              beats_q <= (req_kind_i == `BB_KIND_RMW) ? 2'h0 : req_beats_i;
              beat_q <= 2'h0;
              rmw_wr_q <= 1'b0;
              busy_o <= 1'b1;
              st_q <= (req_kind_i == `BB_KIND_RMW) ? ST_LOCKWAIT : ST_ADDR;
            end
          end
          ST_LOCKWAIT: begin
            if (!lock_low_q) begin
              st_q <= ST_ADDR;
            end
          end
          ST_ADDR: begin
            if (data_ok) begin
              address_strobe_n_o <= 1'b0;
              write_read_o <= cur_wr;
              transceiver_direction_o <= cur_wr;
              addr_hi_o <= addr_q[31:16];
              addr_hi_oe_o <= 1'b1;
              ad_o <= addr_q[15:0];
              ad_oe_o <= 1'b1;
              if (kind_q == `BB_KIND_IACK || (kind_q == `BB_KIND_RMW && !rmw_wr_q)) begin
                lock_n_o <= 1'b0;
                lock_oe_o <= 1'b1;
              end else if (kind_q == `BB_KIND_RMW) begin
                lock_n_o <= 1'b1;
                lock_oe_o <= 1'b0;
              end
              st_q <= ST_DATA;
            end
          end
          ST_DATA: begin
            address_strobe_n_o <= 1'b1;
            data_window_strobe_n_o <= 1'b0;
            burst_final_n_o <= !last_beat;
            // Reads release the bus here, on the same edge that asserts the data-window strobe and lets external drivers start.
            ad_oe_o <= cur_wr;
            if (cur_wr) begin
              ad_o <= wf_data;
            end
            if (!address_strobe_n_o) begin
              // First data cycle only presents data; the ready sample follows.
            end else if (rdy_hit && data_ok) begin
              rdy_used_q <= 1'b1;
              if (!cur_wr) begin
                rd_data_o <= ad_s2_q;
                rd_valid_o <= 1'b1;
              end
              addr_q[3:1] <= addr_q[3:1] + 3'h1;
              if (last_beat) begin
                data_window_strobe_n_o <= 1'b1;
                burst_final_n_o <= 1'b1;
                st_q <= ST_RECOV;
              end else begin
                beat_q <= beat_q + 2'h1;
              end
            end
          end
          ST_RECOV: begin
            ad_oe_o <= 1'b0;
            if (kind_q == `BB_KIND_IACK) begin
              lock_n_o <= 1'b1;
              lock_oe_o <= 1'b0;
            end
            if (kind_q == `BB_KIND_RMW && !rmw_wr_q) begin
              rmw_wr_q <= 1'b1;
              beat_q <= 2'h0;
              st_q <= ST_ADDR;
            end else begin
              // Direction returns high here, with the data-window strobe already high.
              transceiver_direction_o <= 1'b1;
              addr_hi_oe_o <= 1'b0;
              st_q <= ST_IDLE;
            end
          end
          ST_FLOAT: begin
            ad_oe_o <= 1'b0;
            addr_hi_oe_o <= 1'b0;
            lock_oe_o <= 1'b0;
            ctl_oe_o <= 1'b0;
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
  // Lock is driven only low; the pull-up supplies the high level.
endmodule // burst_bus_control
`default_nettype wire

// >>> tb/burst_bus_control_asserts.sv
// Concurrent checks on the burst bus control outputs.
`timescale 1ns/1ps
`default_nettype none
module burst_bus_control_asserts (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic ready_n_i,
  input wire logic lock_n_i,
  input wire logic ad_oe_o,
  input wire logic write_read_o,
  input wire logic address_strobe_n_o,
  input wire logic data_window_strobe_n_o,
  input wire logic transceiver_direction_o,
  input wire logic burst_final_n_o,
  input wire logic ctl_oe_o,
  input wire logic lock_oe_o,
  input wire logic float_all_mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [3:0] rdy_age_q;
  // Ready reaches the sequencer through a synchroniser, so the strobe may lag it a few cycles.
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) rdy_age_q <= 4'hf;
    else if (!ready_n_i) rdy_age_q <= 4'h0;
    else if (rdy_age_q != 4'hf) rdy_age_q <= rdy_age_q + 4'h1;
  end
  property p_rst;
    disable iff (1'b0) !rstn_i && ce_i |=> data_window_strobe_n_o && transceiver_direction_o;
  endproperty
  a_rst: assert property (p_rst) else $error("strobe or direction wrong in reset");
  property p_as;
    $fell(address_strobe_n_o) |=> address_strobe_n_o && !data_window_strobe_n_o;
  endproperty
  a_as: assert property (p_as) else $error("address state not followed by data state");
  property p_dir;
    !address_strobe_n_o |-> transceiver_direction_o == write_read_o;
  endproperty
  a_dir: assert property (p_dir) else $error("direction disagrees with write/read");
  property p_wr;
    !data_window_strobe_n_o |-> $stable(write_read_o) && $stable(transceiver_direction_o);
  endproperty
  a_wr: assert property (p_wr) else $error("write/read or direction moved in data");
  property p_oe;
    !data_window_strobe_n_o && !transceiver_direction_o |-> !ad_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("lines driven in read data state");
  property p_den;
    $rose(data_window_strobe_n_o) |-> rdy_age_q <= 4'h7;
  endproperty
  a_den: assert property (p_den) else $error("data window closed without ready");
  property p_last;
    !burst_final_n_o |-> !data_window_strobe_n_o;
  endproperty
  a_last: assert property (p_last) else $error("burst final outside data state");
  property p_lk;
    $rose(lock_oe_o) |-> $past(lock_n_i) && !address_strobe_n_o && !write_read_o;
  endproperty
  a_lk: assert property (p_lk) else $error("lock taken busy or outside read address");
  property p_ul;
    $fell(lock_oe_o) && write_read_o |-> !address_strobe_n_o;
  endproperty
  a_ul: assert property (p_ul) else $error("lock released outside write address");
  property p_fl;
    float_all_mode_o |-> !ctl_oe_o && !ad_oe_o && !lock_oe_o;
  endproperty
  a_fl: assert property (p_fl) else $error("output driven in float mode");
endmodule // burst_bus_control_asserts
bind burst_bus_control burst_bus_control_asserts burst_bus_control_asserts_i (.*);
`default_nettype wire

// >>> tb/bus_agent_model.sv
// Behavioural memory agent on the far side of the burst bus.
`timescale 1ns/1ps
`default_nettype none
module bus_agent_model (
  input wire logic core_clk_i,
  input wire logic data_window_strobe_n_i,
  input wire logic transceiver_direction_i,
  input wire logic [3:0] wait_cycles_i,
  output logic ready_n_o,
  output logic [15:0] ad_drive_o
);
  logic [3:0] cnt_q = 4'h0;
  logic [15:0] word_q = 16'ha500;
  // The agent stays deaf at least five cycles after a pulse so the late synchroniser sees one beat.
  always @(posedge core_clk_i) begin
    ready_n_o <= 1'b1;
    if (data_window_strobe_n_i) begin
      cnt_q <= 4'h0;
      word_q <= 16'ha500;
    end else begin
      if (cnt_q == wait_cycles_i || cnt_q == wait_cycles_i + 4'h1) ready_n_o <= 1'b0;
      if (cnt_q == wait_cycles_i + 4'h6) begin
        cnt_q <= 4'h0;
        word_q <= word_q + 16'h0001;
      end else cnt_q <= cnt_q + 4'h1;
    end
  end
  assign ad_drive_o = (!data_window_strobe_n_i && !transceiver_direction_i) ? word_q : ~word_q;
endmodule // bus_agent_model
`default_nettype wire

// >>> tb/tb_burst_bus_control.sv
// Self-checking testbench for the burst bus control block.
`timescale 1ns/1ps
`default_nettype none
`include "burst_bus_defines.vh"
module tb_burst_bus_control;
  logic core_clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, rd_ready_i = 1'b1, hold_q = 1'b0;
  logic req_valid_i = 1'b0, wr_valid_i = 1'b0, lock_seen = 1'b0, as_seen = 1'b0, rdy_prev = 1'b1;
  logic [1:0] req_kind_i = 2'h0, req_beats_i = 2'h0;
  logic [31:0] req_addr_i = 32'h0000_1000;
  logic [15:0] wr_data_i = 16'h0000;
  logic [3:0] wait_q = 4'h0;
  logic req_ready_o, wr_ready_o, rd_valid_o, busy_o, ad_oe_o, addr_hi_oe_o, write_read_o;
  logic address_strobe_n_o, data_window_strobe_n_o, transceiver_direction_o, burst_final_n_o;
  logic ctl_oe_o, lock_n_o, lock_oe_o, float_all_mode_o, ready_n_i;
  logic [15:0] rd_data_o, ad_o, ad_drive;
  logic [31:16] addr_hi_o;
  logic [15:0] got_q[$];
  int err_count = 0, checked = 0, cyc = 0;
  wire [15:0] ad_i = ad_oe_o ? ad_o : ad_drive;
  wire lock_n_i = !(lock_oe_o || hold_q);
  burst_bus_control burst_bus_control_i (.*);
  bus_agent_model bus_agent_model_i (.core_clk_i(core_clk_i),
    .data_window_strobe_n_i(data_window_strobe_n_o), .transceiver_direction_i(transceiver_direction_o),
    .wait_cycles_i(wait_q), .ready_n_o(ready_n_i), .ad_drive_o(ad_drive));
  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (rd_valid_o) got_q.push_back(rd_data_o);
    if (!data_window_strobe_n_o && transceiver_direction_o && !ready_n_i && rdy_prev)
      got_q.push_back(ad_o);
    rdy_prev = ready_n_i;
    if (lock_oe_o) lock_seen = 1'b1;
    if (!address_strobe_n_o) as_seen = 1'b1;
    if (cyc > 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task do_reset(input logic strap);
    hold_q <= strap;
    rstn_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    chk({data_window_strobe_n_o, transceiver_direction_o, burst_final_n_o}, 16'h0007);
    rstn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    hold_q <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask
  task start(input logic [1:0] kind, input logic [1:0] beats);
    got_q.delete();
    lock_seen = 1'b0;
    as_seen = 1'b0;
    req_kind_i <= kind;
    req_beats_i <= beats;
    req_valid_i <= 1'b1;
    @(posedge core_clk_i);
    while (req_ready_o !== 1'b1) @(posedge core_clk_i);
    req_valid_i <= 1'b0;
  endtask
  task finish();
    while (busy_o !== 1'b0) @(posedge core_clk_i);
    repeat (3) @(posedge core_clk_i);
  endtask
  task push_words(input int n, input logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      wr_data_i <= base + 16'(i);
      wr_valid_i <= 1'b1;
      @(posedge core_clk_i);
      while (wr_ready_o !== 1'b1) @(posedge core_clk_i);
    end
    wr_valid_i <= 1'b0;
  endtask
  task expect_words(input int n, input logic [15:0] base);
    chk(16'(got_q.size()), 16'(n));
    for (int i = 0; i < n && i < got_q.size(); i++) chk(got_q[i], base + 16'(i));
  endtask
  task t_read(input logic [1:0] beats, input logic [3:0] waits);
    wait_q <= waits;
    start(`BB_KIND_READ, beats);
    finish();
    expect_words(beats + 1, 16'ha500);
  endtask
  task t_write_fifo();
    push_words(8, 16'hc000);
    @(posedge core_clk_i);
    chk({15'h0000, wr_ready_o}, 16'h0000);
    wait_q <= 4'h3;
    for (int k = 0; k < 2; k++) begin
      start(`BB_KIND_WRITE, 2'h3);
      finish();
      expect_words(4, 16'hc000 + 16'(4 * k));
    end
  endtask
  task t_rmw_locked();
    push_words(1, 16'h3c3c);
    hold_q <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    start(`BB_KIND_RMW, 2'h0);
    repeat (20) @(posedge core_clk_i);
    chk({15'h0000, as_seen}, 16'h0000);
    hold_q <= 1'b0;
    finish();
    chk({15'h0000, lock_seen}, 16'h0001);
    chk(16'(got_q.size()), 16'h0002);
    chk(got_q[0], 16'ha500);
    chk(got_q[1], 16'h3c3c);
  endtask
  task t_iack();
    start(`BB_KIND_IACK, 2'h0);
    finish();
    chk({15'h0000, lock_seen}, 16'h0001);
    expect_words(1, 16'ha500);
  endtask
  task t_float();
    do_reset(1'b1);
    chk({14'h0000, float_all_mode_o, ctl_oe_o}, 16'h0002);
    do_reset(1'b0);
    chk({14'h0000, float_all_mode_o, ctl_oe_o}, 16'h0001);
  endtask
  task wrap_up();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    @(posedge core_clk_i);
    do_reset(1'b0);
    t_read(2'h0, 4'h0);
    t_read(2'h3, 4'h2);
    t_write_fifo();
    t_rmw_locked();
    t_iack();
    t_float();
    t_read(2'h1, 4'h1);
    wrap_up();
  end
endmodule // tb_burst_bus_control
`default_nettype wire
